// ### bench/cbh_host.sv
`timescale 1ns/10ps
`default_nettype none
module cbh_host
(
    input wire logic clk,
    input wire logic sda_in,
    output logic scl_o,
    output logic sda_low
);
    initial
    begin
        scl_o = 1'b1;
        sda_low = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask
    // One clock pulse, bit sampled at the end of the high phase
    task automatic clk_bit(input logic drive_low, output logic seen);
        tick(4);
        sda_low = drive_low;
        tick(16);
        scl_o = 1'b1;
        tick(20);
        seen = sda_in;
        scl_o = 1'b0;
    endtask
    task automatic start;
        tick(4);
        sda_low = 1'b0;
        tick(16);
        scl_o = 1'b1;
        tick(20);
        sda_low = 1'b1;
        tick(20);
        scl_o = 1'b0;
    endtask
    task automatic stop;
        tick(4);
        sda_low = 1'b1;
        tick(16);
        scl_o = 1'b1;
        tick(20);
        sda_low = 1'b0;
        tick(20);
    endtask
    task automatic wbyte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--)
            clk_bit(!b[i], s);
        clk_bit(1'b0, s);
        ack = !s;
    endtask
    task automatic rbyte(output logic [7:0] b, input logic last);
        logic s;
        for (int i = 7; i >= 0; i--)
            clk_bit(1'b0, b[i]);
        clk_bit(!last, s);
    endtask
endmodule // cbh_host
`default_nettype wire

// ### bench/test_clock_buffer_host_control.sv
`timescale 1ns/10ps
`default_nettype none
module test_clock_buffer_host_control
    import cbh_pkg::*;
;
    typedef logic [7:0] cbh_bytes_t[$];
    logic clk, rst_n, mode_select, source_choice_low, source_choice_high;
    logic clk_in0_p, clk_in1_p, crystal_in, output_impedance_pick;
    logic bus_addr_strap_low, bus_addr_strap_high, scl_i, host_low;
    logic [7:0] per_output_enable_n;
    logic [1:0] disabled_level_pins;
    logic sda_o, sda_oe, bus_mode, impedance_85;
    logic [1:0] source_route, xtal_series_res;
    logic [7:0] out_active, xtal_load_cap;
    logic [15:0] out_disabled_level;
    logic [4:0] xtal_gain;
    wire logic sda;
    int fails, checks;
    int mdl[128];
    int gvals[8] = '{1, 2, 3, 4, 8, 16, 24, 5};
    assign sda = !((sda_oe && !sda_o) || host_low);
    always #2.5 clk = !clk;
    always #32 clk_in0_p = !clk_in0_p;
    always #31 clk_in1_p = !clk_in1_p;
    always #33 crystal_in = !crystal_in;
    cbh_host host (.clk, .sda_in(sda), .scl_o(scl_i), .sda_low(host_low));
    cbh_ctrl dut (.clk, .rst_n, .mode_select, .source_choice_low, .source_choice_high, .clk_in0_p, .clk_in1_p,
        .crystal_in, .per_output_enable_n, .disabled_level_pins, .output_impedance_pick, .bus_addr_strap_low,
        .bus_addr_strap_high, .scl_i, .sda_i(sda), .sda_o, .sda_oe, .bus_mode, .source_route, .out_active,
        .out_disabled_level, .impedance_85, .xtal_load_cap, .xtal_gain, .xtal_series_res);
    task automatic end_sim;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk_val(input string name, input logic [15:0] exp, input logic [15:0] got);
        checks++;
        if (got !== exp)
        begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic chk_rng(input string name, input int lo, input int hi, input int got);
        checks++;
        if (got < lo || got > hi)
        begin
            fails++;
            $display("MISMATCH %s expected %0d..%0d seen %0d", name, lo, hi, got);
        end
    endtask
    function automatic logic [1:0] res_of(input int g);
        if (g == 0)
            return 2'h0;
        if (g < 4)
            return 2'h1;
        return (g == 4) ? 2'h2 : 2'h3;
    endfunction
    task automatic mdl_wr(input int a, input int v);
        if (a != 0 || v inside {1, 2, 3, 4, 8, 16, 24})
            mdl[a] = v;
    endtask
    task automatic do_reset(input logic mode);
        @(negedge clk);
        rst_n = 1'b0;
        mode_select = mode;
        repeat (16) @(negedge clk);
        rst_n = 1'b1;
        repeat (20) @(negedge clk);
    endtask
    task automatic bus_wr(input logic [6:0] dev, input logic [6:0] rg, input cbh_bytes_t d, output logic ok);
        logic a;
        host.start();
        host.wbyte({dev, 1'b0}, ok);
        if (ok)
        begin
            host.wbyte({1'b1, rg}, a);
            ok = ok & a;
            foreach (d[i])
            begin
                host.wbyte(d[i], a);
                ok = ok & a;
                mdl_wr(int'(rg) + i, int'(d[i]));
            end
        end
        host.stop();
    endtask
    task automatic bus_rd(input logic [6:0] dev, input logic [6:0] rg, input int n);
        logic a;
        logic [7:0] b;
        host.start();
        host.wbyte({dev, 1'b0}, a);
        host.wbyte({1'b1, rg}, a);
        host.start();
        host.wbyte({dev, 1'b1}, a);
        chk_val("read ack", 16'h1, 16'(a));
        for (int i = 0; i < n; i++)
        begin
            host.rbyte(b, i == n - 1);
            chk_val("read data", 16'(mdl[int'(rg) + i]), 16'(b));
        end
        host.stop();
    endtask
    task automatic oe_case(input int k, input logic req_n, input int halves);
        realtime t0;
        int n;
        @(posedge clk_in0_p);
        @(negedge clk);
        per_output_enable_n[k] = req_n;
        @(negedge clk_in0_p);
        t0 = $realtime;
        n = 0;
        while (out_active[k] !== !req_n && n < 300)
        begin
            @(negedge clk);
            n++;
        end
        chk_rng("oe delay", halves * 32, halves * 32 + 60, int'($realtime - t0));
        chk_val("other out", 16'h1, 16'(out_active[k ^ 1]));
        if (n == 300)
        begin
            fails++;
            end_sim();
        end
    endtask
    initial
    begin
        logic ok;
        logic [6:0] dev;
        logic [7:0] v;
        int k;
        fails = 0;
        checks = 0;
        clk = 1'b0;
        clk_in0_p = 1'b0;
        clk_in1_p = 1'b0;
        crystal_in = 1'b0;
        rst_n = 1'b0;
        mode_select = 1'b0;
        source_choice_low = 1'b0;
        source_choice_high = 1'b0;
        per_output_enable_n = 8'h00;
        output_impedance_pick = 1'b0;
        mdl[0] = 4;
        mdl[2] = 8'h40;
        mdl[8] = 8'hff;
        void'($urandom(32'hde350e1c));
        disabled_level_pins = 2'($urandom_range(3));
        bus_addr_strap_low = 1'($urandom_range(1));
        bus_addr_strap_high = 1'($urandom_range(1));
        dev = ADDR_BASE + {5'h0, bus_addr_strap_high, bus_addr_strap_low};
        mdl[int'(REG_DEVADDR)] = int'({bus_addr_strap_high, bus_addr_strap_low});
        do_reset(1'b0);
        chk_val("bus mode", 16'h0, 16'(bus_mode));
        chk_val("enables", 16'hff, 16'(out_active));
        chk_val("load cap", 16'h2b, 16'(xtal_load_cap));
        chk_val("series", 16'h2, 16'(xtal_series_res));
        $display("test reset done");
        for (int i = 0; i < 4; i++)
        begin
            {source_choice_high, source_choice_low} = 2'(i);
            repeat (12) @(negedge clk);
            chk_val("route", (i > 1) ? 16'h2 : 16'(i), 16'(source_route));
        end
        {source_choice_high, source_choice_low} = 2'h0;
        for (int i = 0; i < 2; i++)
        begin
            output_impedance_pick = 1'(i);
            #1;
            chk_val("impedance", 16'(i), 16'(impedance_85));
        end
        bus_wr(dev, REG_CAP, {8'h11}, ok);
        chk_val("pin mode ack", 16'h0, 16'(ok));
        chk_val("pin mode cap", 16'h2b, 16'(xtal_load_cap));
        k = $urandom_range(7);
        oe_case(k, 1'b1, 9);
        chk_val("dis level", 16'({8{disabled_level_pins}}), out_disabled_level);
        oe_case(k, 1'b0, 7);
        $display("test pin control done");
        do_reset(1'b1);
        chk_val("bus mode", 16'h1, 16'(bus_mode));
        chk_val("load cap", 16'h40, 16'(xtal_load_cap));
        mode_select = 1'b0;
        repeat (20) @(negedge clk);
        chk_val("mode held", 16'h1, 16'(bus_mode));
        bus_wr(dev ^ 7'h1, REG_CAP, {8'h11}, ok);
        chk_val("foreign ack", 16'h0, 16'(ok));
        v = 8'($urandom);
        bus_wr(dev, REG_CAP, {v}, ok);
        chk_val("own ack", 16'h1, 16'(ok));
        chk_val("load cap", 16'(v), 16'(xtal_load_cap));
        bus_rd(dev, REG_CAP, 1);
        $display("test byte access done");
        v = 8'($urandom);
        bus_wr(dev, REG_DSTATE0, {v, ~v}, ok);
        chk_val("burst ack", 16'h1, 16'(ok));
        chk_val("dis level regs", {~v, v}, out_disabled_level);
        bus_rd(dev, REG_INSEL, 3);
        foreach (gvals[i])
        begin
            bus_wr(dev, REG_GAIN, {8'(gvals[i])}, ok);
            chk_val("gain", 16'(mdl[0]), 16'(xtal_gain));
            chk_val("series", 16'(res_of(mdl[0])), 16'(xtal_series_res));
        end
        bus_rd(dev, REG_GAIN, 1);
        bus_rd(dev, REG_DEVADDR, 1);
        for (int i = 1; i < 4; i++)
        begin
            bus_wr(dev, REG_INSEL, {8'(i)}, ok);
            chk_val("route reg", (i > 1) ? 16'h2 : 16'(i), 16'(source_route));
        end
        v = ~((8'h1 << k) | 8'h01);
        bus_wr(dev, REG_OUTEN, {v}, ok);
        repeat (100) @(negedge clk);
        chk_val("reg disable", 16'(v), 16'(out_active));
        bus_wr(dev, REG_OUTEN, {8'hff}, ok);
        repeat (100) @(negedge clk);
        chk_val("reg enable", 16'hff, 16'(out_active));
        $display("test bus control done");
        end_sim();
    end
endmodule // test_clock_buffer_host_control
`default_nettype wire

// ### verilog/cbh_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
module cbh_ctrl
    import cbh_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic mode_select,
    input wire logic source_choice_low,
    input wire logic source_choice_high,
    input wire logic clk_in0_p,
    input wire logic clk_in1_p,
    input wire logic crystal_in,
    input wire logic [NUM_OUT-1:0] per_output_enable_n,
    input wire logic [1:0] disabled_level_pins,
    input wire logic output_impedance_pick,
    input wire logic bus_addr_strap_low,
    input wire logic bus_addr_strap_high,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    output logic bus_mode,
    output logic [1:0] source_route,
    output logic [NUM_OUT-1:0] out_active,
    output logic [2*NUM_OUT-1:0] out_disabled_level,
    output logic impedance_85,
    output logic [7:0] xtal_load_cap,
    output logic [4:0] xtal_gain,
    output logic [1:0] xtal_series_res
);
    function automatic logic gain_ok(input logic [4:0] g);
        gain_ok = (g == 5'h01) || (g == 5'h02) || (g == 5'h03) || (g == 5'h04) ||
            (g == 5'h08) || (g == 5'h10) || (g == 5'h18);
    endfunction

    function automatic logic [1:0] series_res(input logic [4:0] g);
        if (g == 5'h00)
            series_res = RES_OPEN;
        else if (g < 5'h04)
            series_res = RES_550;
        else if (g == 5'h04)
            series_res = RES_150;
        else
            series_res = RES_ZERO;
    endfunction

    // Input synchronisers
    logic [NUM_SYNC-1:0] s1_ff, s2_ff, s3_ff, lvl_ff, nxt_lvl;
    logic [NUM_SYNC-1:0] pins;
    assign pins = {per_output_enable_n, disabled_level_pins, source_choice_high, source_choice_low,
        bus_addr_strap_high, bus_addr_strap_low, clk_in0_p, clk_in1_p, crystal_in, scl_i, sda_i, mode_select};

    always_comb
    begin
        for (int i = 0; i < NUM_SYNC; i++)
            nxt_lvl[i] = (s2_ff[i] == s3_ff[i]) ? s3_ff[i] : lvl_ff[i];
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s1_ff <= '0;
            s2_ff <= '0;
            s3_ff <= '0;
            lvl_ff <= '0;
        end
        else
        begin
            s1_ff <= pins;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            lvl_ff <= nxt_lvl;
        end
    end

    // Mode capture once after reset
    logic [2:0] mcnt_ff, nxt_mcnt;
    logic mode_ff, nxt_mode;

    always_comb
    begin
        nxt_mcnt = mcnt_ff;
        nxt_mode = mode_ff;
        if (mcnt_ff != MODE_LATCH_CYCLES)
        begin
            nxt_mcnt = mcnt_ff + 3'h1;
            if (mcnt_ff == MODE_LATCH_CYCLES - 3'h1)
                nxt_mode = nxt_lvl[P_MODE];
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mcnt_ff <= '0;
            mode_ff <= 1'b0;
        end
        else
        begin
            mcnt_ff <= nxt_mcnt;
            mode_ff <= nxt_mode;
        end
    end

    // Bus registers
    logic [4:0] gain_ff, nxt_gain;
    logic [7:0] cap_ff, nxt_cap;
    logic [1:0] insel_ff, nxt_insel;
    logic [2*NUM_OUT-1:0] dstate_ff, nxt_dstate;
    logic [NUM_OUT-1:0] outen_ff, nxt_outen;
    logic [6:0] own_addr;
    assign own_addr = ADDR_BASE + {5'h00, lvl_ff[P_SA_HI], lvl_ff[P_SA_LO]};

    function automatic logic [7:0] rd_reg(input logic [6:0] a);
        case (a)
            REG_GAIN: rd_reg = {3'h0, gain_ff};
            REG_CAP: rd_reg = cap_ff;
            REG_INSEL: rd_reg = {6'h00, insel_ff};
            REG_DSTATE0: rd_reg = dstate_ff[7:0];
            REG_DSTATE1: rd_reg = dstate_ff[15:8];
            REG_OUTEN: rd_reg = outen_ff;
            REG_DEVADDR: rd_reg = {6'h00, lvl_ff[P_SA_HI], lvl_ff[P_SA_LO]};
            default: rd_reg = 8'h00;
        endcase
    endfunction

    // Two-wire client
    cbh_state_t st_ff, nxt_st, after_ff, nxt_after;
    logic [3:0] bcnt_ff, nxt_bcnt;
    logic [7:0] sh_ff, nxt_sh;
    logic [6:0] ptr_ff, nxt_ptr;
    logic oe_ff, nxt_oe;
    logic scl_d_ff, sda_d_ff;
    logic scl_rise, scl_fall, bus_start, bus_stop, wr_en;
    assign scl_rise = !scl_d_ff && lvl_ff[P_SCL];
    assign scl_fall = scl_d_ff && !lvl_ff[P_SCL];
    assign bus_start = mode_ff && scl_d_ff && lvl_ff[P_SCL] && sda_d_ff && !lvl_ff[P_SDA];
    assign bus_stop = scl_d_ff && lvl_ff[P_SCL] && !sda_d_ff && lvl_ff[P_SDA];
    assign wr_en = scl_fall && st_ff == ST_WDATA && bcnt_ff == 4'h8;

    always_comb
    begin
        nxt_st = st_ff;
        nxt_after = after_ff;
        nxt_bcnt = bcnt_ff;
        nxt_sh = sh_ff;
        nxt_ptr = ptr_ff;
        nxt_oe = oe_ff;
        if (bus_start)
        begin
            nxt_st = ST_ADDR;
            nxt_bcnt = 4'h0;
            nxt_oe = 1'b0;
        end
        else if (bus_stop || !mode_ff)
        begin
            nxt_st = ST_IDLE;
            nxt_oe = 1'b0;
        end
        else if (scl_rise)
        begin
            case (st_ff)
                ST_ADDR, ST_CMD, ST_WDATA:
                begin
                    nxt_sh = {sh_ff[6:0], lvl_ff[P_SDA]};
                    nxt_bcnt = bcnt_ff + 4'h1;
                end
                ST_RACK:
                    if (lvl_ff[P_SDA])
                        nxt_st = ST_IDLE;
                default: nxt_st = st_ff;
            endcase
        end
        else if (scl_fall)
        begin
            case (st_ff)
                ST_ADDR:
                    if (bcnt_ff == 4'h8)
                    begin
                        if (sh_ff[7:1] == own_addr)
                        begin
                            nxt_st = ST_ACK;
                            nxt_oe = 1'b1;
                            nxt_after = sh_ff[0] ? ST_RDATA : ST_CMD;
                        end
                        else
                            nxt_st = ST_IDLE;
                    end
                ST_CMD:
                    if (bcnt_ff == 4'h8)
                    begin
                        nxt_ptr = sh_ff[6:0];
                        nxt_st = ST_ACK;
                        nxt_oe = 1'b1;
                        nxt_after = ST_WDATA;
                    end
                ST_WDATA:
                    if (bcnt_ff == 4'h8)
                    begin
                        nxt_ptr = ptr_ff + 7'h01;
                        nxt_st = ST_ACK;
                        nxt_oe = 1'b1;
                        nxt_after = ST_WDATA;
                    end
                ST_ACK, ST_RACK:
                begin
                    nxt_st = nxt_after;
                    nxt_bcnt = 4'h0;
                    nxt_oe = 1'b0;
                    if (after_ff == ST_RDATA)
                    begin
                        nxt_st = ST_RDATA;
                        nxt_sh = rd_reg(ptr_ff);
                        nxt_oe = !nxt_sh[7];
                        nxt_ptr = ptr_ff + 7'h01;
                        nxt_bcnt = 4'h1;
                    end
                end
                ST_RDATA:
                    if (bcnt_ff == 4'h8)
                    begin
                        nxt_st = ST_RACK;
                        nxt_oe = 1'b0;
                    end
                    else
                    begin
                        nxt_sh = {sh_ff[6:0], 1'b0};
                        nxt_oe = !sh_ff[6];
                        nxt_bcnt = bcnt_ff + 4'h1;
                    end
                default: nxt_st = st_ff;
            endcase
        end
    end

    always_comb
    begin
        nxt_gain = gain_ff;
        nxt_cap = cap_ff;
        nxt_insel = insel_ff;
        nxt_dstate = dstate_ff;
        nxt_outen = outen_ff;
        if (wr_en)
        begin
            case (ptr_ff)
                REG_GAIN:
                    if (gain_ok(sh_ff[4:0]))
                        nxt_gain = sh_ff[4:0];
                REG_CAP: nxt_cap = sh_ff;
                REG_INSEL: nxt_insel = sh_ff[1:0];
                REG_DSTATE0: nxt_dstate[7:0] = sh_ff;
                REG_DSTATE1: nxt_dstate[15:8] = sh_ff;
                REG_OUTEN: nxt_outen = sh_ff;
                default: nxt_outen = outen_ff;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_ff <= ST_IDLE;
            after_ff <= ST_IDLE;
            bcnt_ff <= '0;
            sh_ff <= '0;
            ptr_ff <= '0;
            oe_ff <= 1'b0;
            scl_d_ff <= 1'b0;
            sda_d_ff <= 1'b0;
            gain_ff <= GAIN_RST;
            cap_ff <= CAP_RST;
            insel_ff <= SRC_IN0;
            dstate_ff <= '0;
            outen_ff <= '1;
        end
        else
        begin
            st_ff <= nxt_st;
            after_ff <= nxt_after;
            bcnt_ff <= nxt_bcnt;
            sh_ff <= nxt_sh;
            ptr_ff <= nxt_ptr;
            oe_ff <= nxt_oe;
            scl_d_ff <= lvl_ff[P_SCL];
            sda_d_ff <= lvl_ff[P_SDA];
            gain_ff <= nxt_gain;
            cap_ff <= nxt_cap;
            insel_ff <= nxt_insel;
            dstate_ff <= nxt_dstate;
            outen_ff <= nxt_outen;
        end
    end

    // Source routing and selected clock edges
    logic [1:0] src_ff, nxt_src;
    logic sel_lvl, sel_d_ff, sel_edge, sel_fall;

    always_comb
    begin
        if (mode_ff)
            nxt_src = insel_ff[1] ? SRC_XTAL : insel_ff;
        else if (lvl_ff[P_SEL_HI])
            nxt_src = SRC_XTAL;
        else
            nxt_src = lvl_ff[P_SEL_LO] ? SRC_IN1 : SRC_IN0;
        case (src_ff)
            SRC_IN0: sel_lvl = lvl_ff[P_IN0];
            SRC_IN1: sel_lvl = lvl_ff[P_IN1];
            default: sel_lvl = lvl_ff[P_XTAL];
        endcase
    end
    assign sel_edge = sel_d_ff != sel_lvl;
    assign sel_fall = sel_d_ff && !sel_lvl;

    // Per-output enable sequencing
    logic [NUM_OUT-1:0] req_ff, nxt_req, act_ff, nxt_act, en_req;
    logic [3:0] cnt_ff [NUM_OUT], nxt_cnt [NUM_OUT];

    always_comb
    begin
        for (int i = 0; i < NUM_OUT; i++)
        begin
            en_req[i] = !lvl_ff[P_OE+i] && (!mode_ff || outen_ff[i]);
            nxt_req[i] = req_ff[i];
            nxt_act[i] = act_ff[i];
            nxt_cnt[i] = cnt_ff[i];
            if (cnt_ff[i] != 4'h0)
            begin
                if (sel_edge)
                begin
                    nxt_cnt[i] = cnt_ff[i] - 4'h1;
                    if (cnt_ff[i] == 4'h1)
                        nxt_act[i] = req_ff[i];
                end
            end
            else if (sel_fall && en_req[i] != act_ff[i])
            begin
                nxt_req[i] = en_req[i];
                nxt_cnt[i] = en_req[i] ? ENA_HALVES : DIS_HALVES;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            src_ff <= SRC_IN0;
            sel_d_ff <= 1'b0;
            req_ff <= '1;
            act_ff <= '1;
            for (int i = 0; i < NUM_OUT; i++)
                cnt_ff[i] <= '0;
        end
        else
        begin
            src_ff <= nxt_src;
            sel_d_ff <= sel_lvl;
            req_ff <= nxt_req;
            act_ff <= nxt_act;
            for (int i = 0; i < NUM_OUT; i++)
                cnt_ff[i] <= nxt_cnt[i];
        end
    end

    // Outputs
    assign sda_o = 1'b0;
    assign sda_oe = oe_ff;
    assign bus_mode = mode_ff;
    assign source_route = src_ff;
    assign out_active = act_ff;
    assign impedance_85 = output_impedance_pick;
    assign out_disabled_level = mode_ff ? dstate_ff : {NUM_OUT{lvl_ff[P_DL+1], lvl_ff[P_DL]}};
    assign xtal_load_cap = mode_ff ? cap_ff : CAP_PIN_MODE;
    assign xtal_gain = gain_ff;
    assign xtal_series_res = series_res(gain_ff);

    // Checks
    sequence s_addr_ack;
        scl_fall && st_ff == ST_ADDR && bcnt_ff == 4'h8 && sh_ff[7:1] == own_addr;
    endsequence

    chk_mode_route: assert property (@(posedge clk) disable iff (!rst_n)
        !mode_ff && lvl_ff[P_SEL_HI] |=> src_ff == SRC_XTAL) else $error("xtal not routed");
    chk_mode_fixed: assert property (@(posedge clk) disable iff (!rst_n)
        mcnt_ff == MODE_LATCH_CYCLES |=> $stable(mode_ff)) else $error("mode changed");
    chk_disable_delay: assert property (@(posedge clk) disable iff (!rst_n)
        cnt_ff[0] == 4'h0 && sel_fall && en_req[0] != act_ff[0] |=> cnt_ff[0] == (req_ff[0] ? ENA_HALVES : DIS_HALVES))
        else $error("wrong enable latency");
    chk_switch_edge: assert property (@(posedge clk) disable iff (!rst_n)
        act_ff[0] != $past(act_ff[0]) |-> $past(cnt_ff[0] == 4'h1 && sel_edge)) else $error("output switched off edge");
    chk_imp_async: assert property (@(posedge clk) disable iff (!rst_n)
        impedance_85 == output_impedance_pick) else $error("impedance not async");
    chk_addr_ack: assert property (@(posedge clk) disable iff (!rst_n)
        (s_addr_ack and (!bus_start && !bus_stop)) |=> sda_oe ##0 st_ff == ST_ACK) else $error("no address ack");
    chk_foreign_addr: assert property (@(posedge clk) disable iff (!rst_n)
        scl_fall && st_ff == ST_ADDR && bcnt_ff == 4'h8 && sh_ff[7:1] != own_addr && !bus_start |=> !sda_oe)
        else $error("acked foreign address");
    chk_ptr_step: assert property (@(posedge clk) disable iff (!rst_n)
        wr_en && !bus_start && !bus_stop && mode_ff |=> ptr_ff == $past(ptr_ff) + 7'h01) else $error("pointer stuck");
    chk_cap_pin: assert property (@(posedge clk) disable iff (!rst_n)
        !mode_ff |-> xtal_load_cap == CAP_PIN_MODE) else $error("pin mode cap wrong");
    chk_gain_valid: assert property (@(posedge clk) disable iff (!rst_n)
        gain_ff != $past(gain_ff) |-> gain_ok(gain_ff)) else $error("reserved gain stored");
endmodule // cbh_ctrl
`default_nettype wire

// ### verilog/cbh_pkg.sv
// Function
// - Mode pin low: pins; high: bus registers
// - Mode latched once after reset only
// - Source choice pins: 00 in0, 01 in1, 1x crystal
// - Active-low enable per output, glitch free
// - Enable sampled on selected clock falling edge
// - Disable takes effect 4.5 input cycles later
// - Enable takes effect 3.5 input cycles later
// - Impedance pick is asynchronous: low 100, high 85
// - Client address is 0x34 plus strap value
// - Bus bytes are eight bits, MSB first
// - Burst starts at command register address
// - Byte read returns addressed register contents
// - Written data byte is acknowledged, then next byte or stop
// - Pin mode load capacitance fixed at 8 pF
// - Bus mode load capacitance register programmable
// - Seven gain settings, series resistance follows gain
// - Enables default to enabled state
`default_nettype none
package cbh_pkg;
    localparam int NUM_OUT = 8;
    localparam int NUM_SYNC = 12 + NUM_OUT;
    localparam int P_MODE = 0;
    localparam int P_SDA = 1;
    localparam int P_SCL = 2;
    localparam int P_XTAL = 3;
    localparam int P_IN1 = 4;
    localparam int P_IN0 = 5;
    localparam int P_SA_LO = 6;
    localparam int P_SA_HI = 7;
    localparam int P_SEL_LO = 8;
    localparam int P_SEL_HI = 9;
    localparam int P_DL = 10;
    localparam int P_OE = 12;
    // Filter settles on the fourth edge after release
    localparam logic [2:0] MODE_LATCH_CYCLES = 3'h4;
    localparam logic [1:0] SRC_IN0 = 2'h0;
    localparam logic [1:0] SRC_IN1 = 2'h1;
    localparam logic [1:0] SRC_XTAL = 2'h2;
    // Input cycles, and half input cycles, from sample edge to switch
    localparam real DIS_CYCLES = 4.5;
    localparam real ENA_CYCLES = 3.5;
    localparam logic [3:0] DIS_HALVES = 4'(int'(DIS_CYCLES * 2.0));
    localparam logic [3:0] ENA_HALVES = 4'(int'(ENA_CYCLES * 2.0));
    localparam logic [6:0] ADDR_BASE = 7'h34;
    localparam logic [6:0] REG_GAIN = 7'h00;
    localparam logic [6:0] REG_CAP = 7'h02;
    localparam logic [6:0] REG_INSEL = 7'h04;
    localparam logic [6:0] REG_DSTATE0 = 7'h05;
    localparam logic [6:0] REG_DSTATE1 = 7'h06;
    localparam logic [6:0] REG_OUTEN = 7'h08;
    localparam logic [6:0] REG_DEVADDR = 7'h0a;
    localparam logic [4:0] GAIN_RST = 5'h04;
    localparam logic [7:0] CAP_RST = 8'h40;
    // Nearest code to 8 pF at 0.1875 pF steps
    localparam logic [7:0] CAP_PIN_MODE = 8'h2b;
    localparam logic [1:0] RES_OPEN = 2'h0;
    localparam logic [1:0] RES_550 = 2'h1;
    localparam logic [1:0] RES_150 = 2'h2;
    localparam logic [1:0] RES_ZERO = 2'h3;
    typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_CMD, ST_WDATA, ST_ACK, ST_RDATA, ST_RACK} cbh_state_t;
endpackage
`default_nettype wire
